// >>> rtl/cofd_align.sv
// Address aligner: word, longword and fetch accesses start at an even address
// Assumes: purely combinational, used for data and fetch addresses
`timescale 1ns/100ps
`default_nettype none

module cofd_align #(
	parameter int AW = cofd_pkg::AW
) (
	input  wire logic [AW-1:0]          addr_in,
	input  wire cofd_pkg::cofd_size_t   size_in,
	input  wire logic                   fetch_in,
	output logic      [AW-1:0]          addr_out
);
	import cofd_pkg::*;

	// No fault is raised; the low bit is simply dropped
	always_comb begin
		addr_out = addr_in;
		if (fetch_in || size_in != SZ_B) begin
			addr_out[0] = 1'b0;
		end
	end

endmodule : cofd_align

`default_nettype wire

// >>> rtl/cofd_decode_top.sv
// Operand format and instruction class unit: size legality, alignment,
// big-endian packing, shift, bit and decimal-adjust datapaths, stack forms.
// Assumes: one predecoded instruction per cycle; memory sits outside.
`timescale 1ns/100ps
`default_nettype none

module cofd_decode_top (
	input  wire logic                       clk_in,
	input  wire logic                       rst_b_in,
	input  wire logic [cofd_pkg::AW-1:0]    vector_pc_in,
	input  wire logic                       fetch_adv_in,
	input  wire logic                       op_valid_in,
	input  wire cofd_pkg::cofd_op_t         op_type_in,
	input  wire cofd_pkg::cofd_size_t       op_size_in,
	input  wire cofd_pkg::cofd_stack_e      stack_in,
	input  wire logic [3:0]                 src_sel_in,
	input  wire logic [2:0]                 bit_pos_in,
	input  wire logic [cofd_pkg::AW-1:0]    addr_in,
	input  wire logic                       carry_in,
	input  wire logic                       half_in,
	input  wire logic                       wr_en_in,
	input  wire logic [3:0]                 wr_sel_in,
	input  wire cofd_pkg::cofd_size_t       wr_size_in,
	input  wire logic [31:0]                wr_data_in,
	input  wire logic                       ctrl_wr_in,
	input  wire logic                       trace_in,
	input  wire logic                       int_mask_in,
	input  wire logic [2:0]                 ext_mask_in,
	output logic                            done_out,
	output logic                            legal_out,
	output logic                            undef_out,
	output cofd_pkg::cofd_class_e           class_out,
	output logic [cofd_pkg::AW-1:0]         addr_out,
	output logic [31:0]                     store_data_out,
	output logic [31:0]                     result_out,
	output logic                            carry_out,
	output logic                            zero_out,
	output logic [3:0]                      bcd_hi_out,
	output logic [3:0]                      bcd_lo_out,
	output logic [cofd_pkg::AW-1:0]         fetch_addr_out,
	output logic                            trace_out,
	output logic                            int_mask_out,
	output logic [2:0]                      ext_mask_out
);
	import cofd_pkg::*;

	typedef struct packed {
		logic              done;
		logic              legal;
		logic              undef;
		cofd_class_e       cls;
		logic [AW-1:0]     addr;
		logic [31:0]       store;
		logic [31:0]       result;
		logic              carry;
		logic              zero;
		logic [3:0]        bcd_hi;
		logic [3:0]        bcd_lo;
		logic [AW-1:0]     pc;
		logic [AW-1:0]     fetch;
		logic              trace;
		logic              int_mask;
		logic [2:0]        ext_mask;
	} cofd_out_s;

	cofd_out_s      out_r;
	cofd_out_s      out_nxt;
	logic [31:0]    rd_val;
	logic [31:0]    sp_val;
	logic [31:0]    sp_new;
	logic           sp_wr;
	logic [AW-1:0]  ea_pre;
	logic [AW-1:0]  ea_al;
	logic [AW-1:0]  pc_nxt;
	logic [AW-1:0]  pc_al;
	logic           accept;
	logic           periph;
	logic           stack_op;

	function automatic logic size_ok(input cofd_op_t op, input cofd_size_t sz);
		cofd_class_e c;
		c = op_class(op);
		if (c == CL_BRANCH || c == CL_SYS || c == CL_BLOCK) return 1'b1;
		if (sz > SZ_L) return 1'b0;
		if (op >= OP_MUL_U && op <= OP_DIV_S) return sz != SZ_L;
		if ((op >= OP_ADD_CARRY && op <= OP_DADJ_SUB) || op == OP_TAS) begin
			return sz == SZ_B;
		end
		if (c == CL_BIT || op == OP_PMV_FROM || op == OP_PMV_TO) return sz == SZ_B;
		if (op == OP_LDM || op == OP_STM || op == OP_ADDS || op == OP_SUBS) return sz == SZ_L;
		if (op == OP_ZERO_EXT || op == OP_SIGN_EXT) return sz != SZ_B;
		return 1'b1;
	endfunction : size_ok

	// Returns {carry, result}; kind bit 0 picks right, bits 2:1 the family
	function automatic logic [32:0] shift_op(input logic [31:0] d, input cofd_size_t sz,
		input logic [2:0] kind, input logic c);
		logic [31:0] m;
		logic [31:0] top;
		logic [31:0] dm;
		logic        msb;
		logic        fill;
		m = size_mask(sz);
		top = m ^ (m >> 1);
		dm = d & m;
		msb = |(dm & top);
		unique case (kind[2:1])
			2'h0: fill = kind[0] ? msb : 1'b0;
			2'h1: fill = 1'b0;
			2'h2: fill = kind[0] ? d[0] : msb;
			default: fill = c;
		endcase
		if (!kind[0]) return {msb, ((dm << 1) | {31'h0, fill}) & m};
		else return {d[0], (dm >> 1) | (fill ? top : 32'h0)};
	endfunction : shift_op

	// Returns {carry, zero, byte}; odd codes from five up use the inverted bit
	function automatic logic [9:0] bit_op(input logic [7:0] d, input logic [3:0] k,
		input logic [2:0] pos, input logic c);
		logic [7:0] m;
		logic       bi;
		logic       inv;
		logic [7:0] r;
		logic       co;
		logic       z;
		m = 8'h01 << pos;
		inv = k[0] && k >= 4'h5;
		bi = d[pos] ^ inv;
		r = d;
		co = c;
		z = 1'b0;
		unique case (k)
			4'h0: r = d | m;
			4'h1: r = d & ~m;
			4'h2: r = d ^ m;
			4'h3: z = ~d[pos];
			4'h4, 4'h5: co = bi;
			4'h6, 4'h7: r = (c ^ inv) ? (d | m) : (d & ~m);
			4'h8, 4'h9: co = c & bi;
			4'ha, 4'hb: co = c | bi;
			4'hc, 4'hd: co = c ^ bi;
			default: r = d;
		endcase
		return {co, z, r};
	endfunction : bit_op

	// Two packed digits corrected after a binary add or subtract
	function automatic logic [8:0] dec_adjust(input logic [7:0] d, input logic sub,
		input logic c, input logic h);
		logic [7:0] adj;
		logic       co;
		adj = 8'h00;
		co = c;
		if (sub) begin
			if (c) adj = adj | ADJ_HI;
			if (h) adj = adj | ADJ_LO;
			return {co, d - adj};
		end
		if (c || d > BCD_MAX) begin
			adj = adj | ADJ_HI;
			co = 1'b1;
		end
		if (h || d[3:0] > BCD_DIGIT) adj = adj | ADJ_LO;
		return {co, d + adj};
	endfunction : dec_adjust

	cofd_regfile u_regs (
		.clk_in         (clk_in),
		.rd_sel_in      (src_sel_in),
		.rd_size_in     (op_size_in),
		.rd_data_out    (rd_val),
		.wr_en_in       (wr_en_in),
		.wr_sel_in      (wr_sel_in),
		.wr_size_in     (wr_size_in),
		.wr_data_in     (wr_data_in),
		.sp_wr_en_in    (sp_wr),
		.sp_wr_data_in  (sp_new),
		.sp_out         (sp_val)
	);

	cofd_align #(.AW(AW)) u_data_align (
		.addr_in   (ea_pre),
		.size_in   (op_size_in),
		.fetch_in  (1'b0),
		.addr_out  (ea_al)
	);

	cofd_align #(.AW(AW)) u_fetch_align (
		.addr_in   (pc_nxt),
		.size_in   (SZ_W),
		.fetch_in  (1'b1),
		.addr_out  (pc_al)
	);

	// Decode, legality and stack forms
	always_comb begin
		logic [2:0] nb;
		nb = size_bytes(op_size_in);
		periph = op_type_in == OP_PMV_FROM || op_type_in == OP_PMV_TO;
		stack_op = op_type_in == OP_MOV && stack_in != STK_NONE;
		accept = op_valid_in && op_type_in <= OP_LAST && size_ok(op_type_in, op_size_in)
			&& !periph && !(stack_op && op_size_in == SZ_B);
		ea_pre = addr_in;
		sp_new = sp_val;
		sp_wr = 1'b0;
		if (accept && stack_op) begin
			sp_wr = 1'b1;
			if (stack_in == STK_PUSH) begin
				sp_new = sp_val - {29'h0, nb};
				ea_pre = sp_new[AW-1:0];
			end else begin
				sp_new = sp_val + {29'h0, nb};
				ea_pre = sp_val[AW-1:0];
			end
		end
		pc_nxt = fetch_adv_in ? out_r.pc + FETCH_STEP : out_r.pc;
	end

	// Output stage
	always_comb begin
		cofd_class_e cls;
		logic [32:0] sh;
		logic [9:0]  bo;
		logic [8:0]  da;
		cls = op_class(op_type_in);
		sh = shift_op(rd_val, op_size_in, 3'(op_type_in - OP_SHIFT), carry_in);
		bo = bit_op(rd_val[7:0], 4'(op_type_in - OP_BIT_SET), bit_pos_in, carry_in);
		da = dec_adjust(rd_val[7:0], op_type_in == OP_DADJ_SUB, carry_in, half_in);
		out_nxt = out_r;
		out_nxt.done = op_valid_in;
		out_nxt.legal = accept;
		out_nxt.undef = op_valid_in && !accept;
		out_nxt.cls = op_valid_in ? cls : CL_NONE;
		out_nxt.pc = pc_nxt;
		out_nxt.fetch = pc_al;
		if (accept) begin
			out_nxt.addr = ea_al;
			out_nxt.store = rd_val << (6'd32 - 6'({size_bytes(op_size_in), 3'h0}));
			out_nxt.bcd_hi = rd_val[7:4];
			out_nxt.bcd_lo = rd_val[3:0];
			out_nxt.zero = 1'b0;
			out_nxt.carry = carry_in;
			out_nxt.result = rd_val & size_mask(op_size_in);
			if (cls == CL_SHIFT) begin
				out_nxt.carry = sh[32];
				out_nxt.result = sh[31:0];
			end else if (cls == CL_BIT) begin
				out_nxt.carry = bo[9];
				out_nxt.zero = bo[8];
				out_nxt.result = {24'h0, bo[7:0]};
			end else if (op_type_in == OP_DADJ_ADD || op_type_in == OP_DADJ_SUB) begin
				out_nxt.carry = da[8];
				out_nxt.result = {24'h0, da[7:0]};
			end
		end
		if (ctrl_wr_in) begin
			out_nxt.trace = trace_in;
			out_nxt.int_mask = int_mask_in;
			out_nxt.ext_mask = ext_mask_in;
		end
		if (!rst_b_in) begin
			out_nxt = '0;
			out_nxt.cls = CL_NONE;
			out_nxt.pc = vector_pc_in;
			out_nxt.fetch = {vector_pc_in[AW-1:1], 1'b0};
			out_nxt.trace = TRACE_RST;
			out_nxt.int_mask = INT_MASK_RST;
			out_nxt.ext_mask = EXR_MASK_RST;
		end
	end

	always_ff @(posedge clk_in) begin
		out_r <= out_nxt;
	end

	assign done_out       = out_r.done;
	assign legal_out      = out_r.legal;
	assign undef_out      = out_r.undef;
	assign class_out      = out_r.cls;
	assign addr_out       = out_r.addr;
	assign store_data_out = out_r.store;
	assign result_out     = out_r.result;
	assign carry_out      = out_r.carry;
	assign zero_out       = out_r.zero;
	assign bcd_hi_out     = out_r.bcd_hi;
	assign bcd_lo_out     = out_r.bcd_lo;
	assign fetch_addr_out = out_r.fetch;
	assign trace_out      = out_r.trace;
	assign int_mask_out   = out_r.int_mask;
	assign ext_mask_out   = out_r.ext_mask;

	a_align_data_even: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		op_valid_in && accept && op_size_in != SZ_B |=> !addr_out[0])
		else $error("word or longword address not even");

	a_align_fetch_even: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		fetch_adv_in ##1 1'b1 |-> !fetch_addr_out[0] && fetch_addr_out[AW-1:1] == out_r.pc[AW-1:1])
		else $error("fetch address not even");

	a_periph_move_undef: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		op_valid_in && periph |-> !sp_wr ##1 undef_out && !legal_out && done_out)
		else $error("peripheral move not refused");

	a_muldiv_size_chk: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		op_valid_in && op_type_in >= OP_MUL_U && op_type_in <= OP_DIV_S
		|=> legal_out == ($past(op_size_in) == SZ_B || $past(op_size_in) == SZ_W))
		else $error("multiply or divide size check wrong");

	a_byte_only_ops: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		op_valid_in && op_type_in >= OP_ADD_CARRY && op_type_in <= OP_DADJ_SUB && op_size_in != SZ_B
		|=> undef_out)
		else $error("byte only instruction accepted at wider size");

	a_reset_state_val: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(rst_b_in) |-> trace_out == TRACE_RST && int_mask_out && ext_mask_out == EXR_MASK_RST
		&& out_r.pc == $past(vector_pc_in))
		else $error("reset values not loaded");

	a_bit_set_pos: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		op_valid_in && op_type_in == OP_BIT_SET && op_size_in == SZ_B
		|=> result_out[$past(bit_pos_in)] && result_out[31:8] == 24'h0)
		else $error("bit set missed selected bit");

	a_push_sp_dec: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		accept && stack_op && stack_in == STK_PUSH && !(wr_en_in && wr_sel_in[2:0] == SP_INDEX)
		|=> sp_val == $past(sp_val) - {29'h0, $past(size_bytes(op_size_in))}
		&& addr_out == sp_val[AW-1:0])
		else $error("push did not pre-decrement stack pointer");

	a_big_endian_word: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		accept && op_size_in == SZ_W |=> store_data_out[31:16] == $past(rd_val[15:0]))
		else $error("word store not big-endian");

	a_bcd_digit_split: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		accept |=> {bcd_hi_out, bcd_lo_out} == $past(rd_val[7:0]))
		else $error("decimal digits not split");

endmodule : cofd_decode_top

`default_nettype wire

// >>> rtl/cofd_pkg.sv
// Package: operand sizes, instruction type codes, classes and reset values
// Assumes: instruction type codes arrive already predecoded from the opcode
`default_nettype none

package cofd_pkg;

	localparam int AW = 24;
	localparam int DW = 32;

	typedef logic [1:0] cofd_size_t;
	localparam cofd_size_t SZ_B = 2'h0;
	localparam cofd_size_t SZ_W = 2'h1;
	localparam cofd_size_t SZ_L = 2'h2;

	typedef logic [6:0] cofd_op_t;
	typedef enum logic [1:0] {STK_NONE, STK_PUSH, STK_POP} cofd_stack_e;
	typedef enum logic [3:0] {CL_XFER, CL_ARITH, CL_LOGIC, CL_SHIFT, CL_BIT,
		CL_BRANCH, CL_SYS, CL_BLOCK, CL_NONE} cofd_class_e;

	// Type codes, 65 in all
	localparam cofd_op_t OP_MOV       = 7'h00;
	localparam cofd_op_t OP_LDM       = 7'h01;
	localparam cofd_op_t OP_STM       = 7'h02;
	localparam cofd_op_t OP_PMV_FROM  = 7'h03;
	localparam cofd_op_t OP_PMV_TO    = 7'h04;
	localparam cofd_op_t OP_ARITH     = 7'h05;
	localparam cofd_op_t OP_ADD_CARRY = 7'h09;
	localparam cofd_op_t OP_SUB_CARRY = 7'h0a;
	localparam cofd_op_t OP_DADJ_ADD  = 7'h0b;
	localparam cofd_op_t OP_DADJ_SUB  = 7'h0c;
	localparam cofd_op_t OP_ADDS      = 7'h0f;
	localparam cofd_op_t OP_SUBS      = 7'h10;
	localparam cofd_op_t OP_MUL_U     = 7'h11;
	localparam cofd_op_t OP_DIV_S     = 7'h14;
	localparam cofd_op_t OP_ZERO_EXT  = 7'h15;
	localparam cofd_op_t OP_SIGN_EXT  = 7'h16;
	localparam cofd_op_t OP_TAS       = 7'h17;
	localparam cofd_op_t OP_LOGIC     = 7'h18;
	localparam cofd_op_t OP_SHIFT     = 7'h1c;
	localparam cofd_op_t OP_BIT_SET   = 7'h24;
	localparam cofd_op_t OP_BRANCH    = 7'h32;
	localparam cofd_op_t OP_SYS       = 7'h37;
	localparam cofd_op_t OP_BLOCK     = 7'h40;
	localparam cofd_op_t OP_LAST      = 7'h40;

	localparam logic       TRACE_RST    = 1'b0;
	localparam logic       INT_MASK_RST = 1'b1;
	localparam logic [2:0] EXR_MASK_RST = 3'h7;
	localparam logic [7:0] BCD_MAX      = 8'h99;
	localparam logic [3:0] BCD_DIGIT    = 4'h9;
	localparam logic [7:0] ADJ_LO       = 8'h06;
	localparam logic [7:0] ADJ_HI       = 8'h60;
	localparam logic [AW-1:0] FETCH_STEP = 24'h000002;
	localparam logic [2:0] SP_INDEX     = 3'h7;

	function automatic logic [DW-1:0] size_mask(input cofd_size_t sz);
		unique case (sz)
			SZ_B: return 32'h000000ff;
			SZ_W: return 32'h0000ffff;
			default: return 32'hffffffff;
		endcase
	endfunction : size_mask

	function automatic logic [2:0] size_bytes(input cofd_size_t sz);
		unique case (sz)
			SZ_B: return 3'h1;
			SZ_W: return 3'h2;
			default: return 3'h4;
		endcase
	endfunction : size_bytes

	function automatic cofd_class_e op_class(input cofd_op_t op);
		if (op < OP_ARITH) return CL_XFER;
		else if (op < OP_LOGIC) return CL_ARITH;
		else if (op < OP_SHIFT) return CL_LOGIC;
		else if (op < OP_BIT_SET) return CL_SHIFT;
		else if (op < OP_BRANCH) return CL_BIT;
		else if (op < OP_SYS) return CL_BRANCH;
		else if (op < OP_BLOCK) return CL_SYS;
		else if (op == OP_BLOCK) return CL_BLOCK;
		else return CL_NONE;
	endfunction : op_class

endpackage : cofd_pkg

`default_nettype wire

// >>> rtl/cofd_regfile.sv
// General register file: eight longwords viewed as bytes, words or longwords
// Assumes: one write port plus a dedicated stack pointer port that wins on reg 7
`timescale 1ns/100ps
`default_nettype none

module cofd_regfile (
	input  wire logic                   clk_in,
	input  wire logic [3:0]             rd_sel_in,
	input  wire cofd_pkg::cofd_size_t   rd_size_in,
	output logic      [31:0]            rd_data_out,
	input  wire logic                   wr_en_in,
	input  wire logic [3:0]             wr_sel_in,
	input  wire cofd_pkg::cofd_size_t   wr_size_in,
	input  wire logic [31:0]            wr_data_in,
	input  wire logic                   sp_wr_en_in,
	input  wire logic [31:0]            sp_wr_data_in,
	output logic      [31:0]            sp_out
);
	import cofd_pkg::*;

	// Not reset: contents are undefined until software writes them
	logic [31:0] regs [8];
	logic [31:0] wr_word_nxt;

	// Byte sel[3]=1 is the low half; word sel[3]=1 is the extended upper word
	always_comb begin
		logic [31:0] cur;
		cur = regs[rd_sel_in[2:0]];
		unique case (rd_size_in)
			SZ_B: rd_data_out = {24'h0, rd_sel_in[3] ? cur[7:0] : cur[15:8]};
			SZ_W: rd_data_out = {16'h0, rd_sel_in[3] ? cur[31:16] : cur[15:0]};
			default: rd_data_out = cur;
		endcase
		sp_out = regs[SP_INDEX];
	end

	always_comb begin
		logic [31:0] old;
		old = regs[wr_sel_in[2:0]];
		wr_word_nxt = old;
		unique case (wr_size_in)
			SZ_B: begin
				if (wr_sel_in[3]) wr_word_nxt[7:0] = wr_data_in[7:0];
				else wr_word_nxt[15:8] = wr_data_in[7:0];
			end
			SZ_W: begin
				if (wr_sel_in[3]) wr_word_nxt[31:16] = wr_data_in[15:0];
				else wr_word_nxt[15:0] = wr_data_in[15:0];
			end
			default: wr_word_nxt = wr_data_in;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (wr_en_in && !(sp_wr_en_in && wr_sel_in[2:0] == SP_INDEX)) begin
			regs[wr_sel_in[2:0]] <= wr_word_nxt;
		end
		if (sp_wr_en_in) begin
			regs[SP_INDEX] <= sp_wr_data_in;
		end
	end

endmodule : cofd_regfile

`default_nettype wire

// >>> verif/cofd_decode_top_tb.sv
// Testbench for the operand format and class unit
// Assumes: outputs answer one cycle after each request, reset is synchronous
`timescale 1ns/100ps
`default_nettype none

module cofd_decode_top_tb;
	import cofd_pkg::*;
	logic clk_in, rst_b_in, fetch_adv_in, op_valid_in, carry_in, half_in, wr_en_in, ctrl_wr_in;
	logic trace_in, int_mask_in, mem_wr, done_out, legal_out, undef_out, carry_out, zero_out;
	logic trace_out, int_mask_out;
	logic [23:0] vector_pc_in, addr_in, addr_out, fetch_addr_out;
	logic [31:0] wr_data_in, store_data_out, result_out;
	logic [3:0]  src_sel_in, wr_sel_in, bcd_hi_out, bcd_lo_out;
	logic [2:0]  bit_pos_in, ext_mask_in, ext_mask_out;
	cofd_op_t    op_type_in;
	cofd_size_t  op_size_in, wr_size_in, mem_size;
	cofd_stack_e stack_in;
	cofd_class_e class_out;
	int          miscompares = 0, num_checks = 0, cycles = 0;

	cofd_decode_top cofd_decode_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .vector_pc_in(vector_pc_in),
		.fetch_adv_in(fetch_adv_in), .op_valid_in(op_valid_in), .op_type_in(op_type_in), .op_size_in(op_size_in),
		.stack_in(stack_in), .src_sel_in(src_sel_in), .bit_pos_in(bit_pos_in), .addr_in(addr_in),
		.carry_in(carry_in), .half_in(half_in), .wr_en_in(wr_en_in), .wr_sel_in(wr_sel_in),
		.wr_size_in(wr_size_in), .wr_data_in(wr_data_in), .ctrl_wr_in(ctrl_wr_in), .trace_in(trace_in),
		.int_mask_in(int_mask_in), .ext_mask_in(ext_mask_in), .done_out(done_out), .legal_out(legal_out),
		.undef_out(undef_out), .class_out(class_out), .addr_out(addr_out), .store_data_out(store_data_out),
		.result_out(result_out), .carry_out(carry_out), .zero_out(zero_out), .bcd_hi_out(bcd_hi_out),
		.bcd_lo_out(bcd_lo_out), .fetch_addr_out(fetch_addr_out), .trace_out(trace_out),
		.int_mask_out(int_mask_out), .ext_mask_out(ext_mask_out));
	cofd_mem_model cofd_mem_model_i (.clk_in(clk_in), .wr_in(mem_wr), .size_in(mem_size),
		.addr_in(addr_out), .data_in(store_data_out));

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk

	task summarize;
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic op(input cofd_op_t t, input cofd_size_t s, input cofd_stack_e k, input logic [3:0] src,
		input logic [23:0] a, input logic [2:0] p);
		@(posedge clk_in);
		op_valid_in <= 1'b1;
		op_type_in  <= t;
		op_size_in  <= s;
		stack_in    <= k;
		src_sel_in  <= src;
		addr_in     <= a;
		bit_pos_in  <= p;
		@(posedge clk_in);
		op_valid_in <= 1'b0;
		#1;
	endtask : op

	task automatic wreg(input logic [3:0] r, input cofd_size_t s, input logic [31:0] d);
		@(posedge clk_in);
		wr_en_in   <= 1'b1;
		wr_sel_in  <= r;
		wr_size_in <= s;
		wr_data_in <= d;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	endtask : wreg

	task automatic push_chk(input cofd_stack_e k, input cofd_size_t s, input logic [23:0] ea,
		input logic [31:0] ed);
		op(OP_MOV, s, k, 4'h1, 24'h0, 3'h0);
		chk("legal", 32'h1, 32'(legal_out));
		chk("stack addr", 32'(ea), 32'(addr_out));
		if (k == STK_PUSH) chk("store", ed, store_data_out);
	endtask : push_chk

	task t_ctrl_reset;
		@(posedge clk_in);
		ctrl_wr_in  <= 1'b1;
		trace_in    <= 1'b1;
		int_mask_in <= 1'b0;
		ext_mask_in <= 3'h2;
		@(posedge clk_in);
		ctrl_wr_in <= 1'b0;
		rst_b_in   <= 1'b0;
		#1;
		chk("ext written", 32'h2, 32'(ext_mask_out));
		@(posedge clk_in);
		rst_b_in <= 1'b1;
		#1;
		chk("trace", 32'h0, 32'(trace_out));
		chk("int mask", 32'h1, 32'(int_mask_out));
		chk("ext mask", 32'h7, 32'(ext_mask_out));
		chk("class", 32'(CL_NONE), 32'(class_out));
		chk("fetch reset", 32'h001234, 32'(fetch_addr_out));
	endtask : t_ctrl_reset

	task t_fetch;
		@(posedge clk_in);
		fetch_adv_in <= 1'b1;
		@(posedge clk_in);
		@(posedge clk_in);
		fetch_adv_in <= 1'b0;
		#1;
		chk("fetch", 32'h001238, 32'(fetch_addr_out));
	endtask : t_fetch

	task t_stack;
		wreg(4'h7, SZ_L, 32'h00001000);
		wreg(4'h1, SZ_L, 32'haabbccdd);
		push_chk(STK_PUSH, SZ_W, 24'h000ffe, 32'hccdd0000);
		@(posedge clk_in);
		mem_wr   <= 1'b1;
		mem_size <= SZ_W;
		@(posedge clk_in);
		mem_wr <= 1'b0;
		#1;
		chk("mem msb", 32'hcc, 32'(cofd_mem_model_i.mem_r[12'hffe]));
		chk("mem lsb", 32'hdd, 32'(cofd_mem_model_i.mem_r[12'hfff]));
		op(OP_MOV, SZ_B, STK_PUSH, 4'h1, 24'h0, 3'h0);
		chk("byte push", 32'h1, 32'(undef_out));
		push_chk(STK_PUSH, SZ_L, 24'h000ffa, 32'haabbccdd);
		push_chk(STK_POP, SZ_L, 24'h000ffa, 32'h0);
		push_chk(STK_POP, SZ_W, 24'h000ffe, 32'h0);
	endtask : t_stack

	task t_align;
		op(OP_MOV, SZ_W, STK_NONE, 4'h1, 24'h000101, 3'h0);
		chk("word align", 32'h000100, 32'(addr_out));
		op(OP_MOV, SZ_L, STK_NONE, 4'h1, 24'h000103, 3'h0);
		chk("long align", 32'h000102, 32'(addr_out));
		op(OP_MOV, SZ_B, STK_NONE, 4'h1, 24'h000101, 3'h0);
		chk("byte odd", 32'h000101, 32'(addr_out));
		chk("no error", 32'h1, 32'(legal_out));
	endtask : t_align

	task t_views;
		logic [3:0]  s[5] = '{4'h3, 4'hb, 4'h3, 4'hb, 4'h3};
		cofd_size_t  z[5] = '{SZ_B, SZ_B, SZ_W, SZ_W, SZ_L};
		logic [31:0] e[5] = '{32'h33, 32'h44, 32'h3344, 32'h1122, 32'h11223344};
		wreg(4'h3, SZ_L, 32'h11223344);
		for (int i = 0; i < 5; i++) begin
			op(OP_MOV, z[i], STK_NONE, s[i], 24'h000200, 3'h0);
			chk("view", e[i], result_out);
		end
	endtask : t_views

	task t_legal;
		cofd_op_t   t[14] = '{OP_MUL_U, OP_MUL_U, OP_DIV_S, OP_ADD_CARRY, OP_ADD_CARRY, OP_SUB_CARRY,
			OP_DADJ_ADD, OP_DADJ_SUB, OP_PMV_FROM, OP_PMV_TO, OP_TAS, OP_TAS, OP_MOV, 7'h41};
		cofd_size_t z[14] = '{SZ_W, SZ_L, SZ_B, SZ_B, SZ_W, SZ_W, SZ_B, SZ_L, SZ_B, SZ_B, SZ_B, SZ_W, 2'h3, SZ_B};
		logic       g[14] = '{1, 0, 1, 1, 0, 0, 1, 0, 0, 0, 1, 0, 0, 0};
		// Test-and-set only ever names register 1, at byte or word size
		for (int i = 0; i < 14; i++) begin
			op(t[i], z[i], STK_NONE, 4'h1, 24'h000300, 3'h0);
			chk("legal", 32'(g[i]), 32'(legal_out));
			chk("undef", 32'(!g[i]), 32'(undef_out));
		end
		op(OP_PMV_FROM, SZ_B, STK_NONE, 4'h1, 24'h000777, 3'h0);
		chk("held addr", 32'h000300, 32'(addr_out));
	endtask : t_legal

	task t_datapath;
		wreg(4'h4, SZ_L, 32'h0000003c);
		op(OP_DADJ_ADD, SZ_B, STK_NONE, 4'hc, 24'h0, 3'h0);
		chk("bcd hi", 32'h3, 32'(bcd_hi_out));
		chk("bcd lo", 32'hc, 32'(bcd_lo_out));
		chk("adjust", 32'h42, result_out);
		wreg(4'h5, SZ_L, 32'h00000081);
		op(OP_SHIFT, SZ_B, STK_NONE, 4'hd, 24'h0, 3'h0);
		chk("shift", 32'h02, result_out);
		chk("shift carry", 32'h1, 32'(carry_out));
		op(OP_SHIFT + 7'h1, SZ_B, STK_NONE, 4'hd, 24'h0, 3'h0);
		chk("arith right", 32'hc0, result_out);
		chk("right carry", 32'h1, 32'(carry_out));
		wreg(4'h6, SZ_L, 32'h0);
		for (int p = 0; p < 8; p++) begin
			op(OP_BIT_SET, SZ_B, STK_NONE, 4'he, 24'h0, p[2:0]);
			chk("bit set", 32'h1 << p, result_out);
		end
		op(OP_BIT_SET + 7'h3, SZ_B, STK_NONE, 4'he, 24'h0, 3'h2);
		chk("bit test zero", 32'h1, 32'(zero_out));
		// Subtract adjust with both carry and half carry set
		@(posedge clk_in);
		carry_in <= 1'b1;
		half_in  <= 1'b1;
		op(OP_DADJ_SUB, SZ_B, STK_NONE, 4'hc, 24'h0, 3'h0);
		chk("sub adjust", 32'hd6, result_out);
		chk("sub carry", 32'h1, 32'(carry_out));
	endtask : t_datapath

	function automatic cofd_class_e exp_class(input int t);
		if (t < 5) return CL_XFER;
		if (t < 24) return CL_ARITH;
		if (t < 28) return CL_LOGIC;
		if (t < 36) return CL_SHIFT;
		if (t < 50) return CL_BIT;
		if (t < 55) return CL_BRANCH;
		if (t < 64) return CL_SYS;
		return (t == 64) ? CL_BLOCK : CL_NONE;
	endfunction : exp_class

	task t_classes;
		for (int t = 0; t <= 66; t++) begin
			@(posedge clk_in);
			op_valid_in <= (t < 66);
			op_type_in  <= 7'(t);
			op_size_in  <= SZ_B;
			stack_in    <= STK_NONE;
			src_sel_in  <= 4'h4;
			#1;
			if (t > 0) chk("class", 32'(exp_class(t - 1)), 32'(class_out));
			if (t > 0) chk("done", 32'h1, 32'(done_out));
		end
		@(posedge clk_in);
		#1;
		chk("idle class", 32'(CL_NONE), 32'(class_out));
	endtask : t_classes

	initial begin
		{rst_b_in, fetch_adv_in, op_valid_in, carry_in, half_in, wr_en_in, ctrl_wr_in} = '0;
		{trace_in, int_mask_in, mem_wr, bit_pos_in, ext_mask_in, src_sel_in, wr_sel_in} = '0;
		{addr_in, wr_data_in, op_type_in, op_size_in, wr_size_in, mem_size} = '0;
		vector_pc_in = 24'h001235;
		stack_in     = STK_NONE;
		repeat (10) @(posedge clk_in);
		#1;
		chk("reset ext", 32'h7, 32'(ext_mask_out));
		@(posedge clk_in);
		rst_b_in <= 1'b1;
		t_ctrl_reset();
		t_fetch();
		t_stack();
		t_align();
		t_views();
		t_legal();
		t_datapath();
		t_classes();
		summarize();
	end
endmodule : cofd_decode_top_tb

`default_nettype wire

// >>> verif/cofd_mem_model.sv
// Data memory beside the unit: stores packed operands at the unit's address
// Assumes: bench pulses wr_in for one cycle while the unit's outputs hold
`timescale 1ns/100ps
`default_nettype none

module cofd_mem_model (
	input  wire logic                    clk_in,
	input  wire logic                    wr_in,
	input  wire cofd_pkg::cofd_size_t    size_in,
	input  wire logic [cofd_pkg::AW-1:0] addr_in,
	input  wire logic [31:0]             data_in
);
	import cofd_pkg::*;
	logic [7:0] mem_r [0:4095];
	int         nbytes;
	assign nbytes = (size_in == SZ_B) ? 1 : (size_in == SZ_W) ? 2 : 4;
	// Most significant byte goes to the lowest address
	always_ff @(posedge clk_in) begin
		if (wr_in) begin
			for (int i = 0; i < 4; i++) begin
				if (i < nbytes) begin
					mem_r[addr_in[11:0] + 12'(i)] <= data_in[31-8*i -: 8];
				end
			end
		end
	end
endmodule : cofd_mem_model

`default_nettype wire
